// ### design/pcc_cfg_cmd.sv
// configuration command, status and class/revision registers of the ethernet function
`timescale 1ns/1ps
`default_nettype none
`include "pcc_regs.svh"

module pcc_cfg_cmd #(
  // arbitrary silicon revision code, chosen neutral
  parameter logic [7:0] REVISION = 8'h10
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // configuration cycle port
  input  wire pcc_pkg::pcc_cfg_req_s cfg_req_i,
  output logic                       cfg_ack_o,
  output logic [31:0]                cfg_rdata_o,
  // decode hits and requests from the bus interface
  input  wire logic                  io_hit_i,
  input  wire logic                  mem_hit_i,
  input  wire logic                  special_cycle_i,
  input  wire logic                  master_req_i,
  input  wire logic                  master_active_i,
  input  wire logic                  addr_parity_err_i,
  input  wire logic                  data_parity_err_i,
  input  wire logic                  parity_error_select_i,
  // open-drain error pins
  input  wire logic                  serr_n_i,
  output logic                       serr_n_o,
  output logic                       serr_oe_o,
  input  wire logic                  perr_n_i,
  output logic                       perr_n_o,
  output logic                       perr_oe_o,
  // gated results towards the bus interface and datapath
  output logic                       io_claim_o,
  output logic                       mem_claim_o,
  output logic                       master_grant_o,
  output logic                       master_perr_o,
  output logic                       master_halt_o,
  output logic                       fast_back_to_back_o
);

  localparam pcc_pkg::pcc_state_s RESET_STATE = '{
    cmd:          `PCC_CMD_RESET,
    ack:          1'b0,
    rdata:        32'h0000_0000,
    serr_oe:      1'b0,
    serr_lvl:     1'b1,
    perr_oe:      1'b0,
    perr_lvl:     1'b1,
    io_claim:     1'b0,
    mem_claim:    1'b0,
    master_grant: 1'b0,
    master_perr:  1'b0,
    master_halt:  1'b0
  };

  pcc_pkg::pcc_state_s st_r;
  pcc_pkg::pcc_state_s st_nxt;
  logic                perr_seen_n;
  logic                hit_cmd;
  logic                hit_class;
  logic [31:0]         cmd_stat_word;
  logic [31:0]         class_word;
  logic [15:0]         cmd_wr;
  logic                perr_err;

  // the mask is sliced per byte lane, which a bare literal does not allow
  localparam logic [15:0] CMD_RW_MASK   = `PCC_CMD_RW_MASK;
  localparam logic [15:0] CMD_HARD_ZERO = (16'h0001 << `PCC_CMD_SPECIAL) | (16'h0001 << `PCC_CMD_MWI)
                                        | (16'h0001 << `PCC_CMD_VGA_SNOOP) | (16'h0001 << `PCC_CMD_STEPPING);

  // a hardwired zero bit inside the writable mask could be set by software
  if ((CMD_RW_MASK & CMD_HARD_ZERO) != 16'h0000) begin : g_mask_guard
    $error("writable command mask covers a hardwired bit");
  end

  // bus PERR# is a pin, so it passes the three-stage filter first
  pcc_pin_sync #(
    .RESET_VAL (1'b1)
  ) u_perr_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (perr_n_i),
    .level_o (perr_seen_n)
  );

  // address decode on dword boundaries; byte lanes are handled per byte
  assign hit_cmd   = {cfg_req_i.addr[7:2], 2'b00} == `PCC_OFF_CMD_STAT;
  assign hit_class = {cfg_req_i.addr[7:2], 2'b00} == `PCC_OFF_CLASS_REV;

  // read view of command/status; status half is fixed, reserved bits zero
  assign cmd_stat_word = {`PCC_STS_VALUE, st_r.cmd & `PCC_CMD_RW_MASK};

  // class code and revision are constants
  assign class_word = {`PCC_BASE_CLASS, `PCC_SUB_CLASS, `PCC_PROG_IF, REVISION};

  // a read-only bit keeps zero whatever is written, since the mask clears it
  always_comb begin
    cmd_wr = st_r.cmd;
    if (cfg_req_i.be[0]) begin
      cmd_wr[7:0] = cfg_req_i.wdata[7:0] & CMD_RW_MASK[7:0];
    end
    if (cfg_req_i.be[1]) begin
      cmd_wr[15:8] = cfg_req_i.wdata[15:8] & CMD_RW_MASK[15:8];
    end
  end

  // our own PERR# drive is masked only by its current enable, but the filtered line shows that drive four cycles later
  assign perr_err = !perr_seen_n && master_active_i && !st_r.perr_oe;

  // next state of the whole block
  always_comb begin
    st_nxt = st_r;

    // configuration access: answer one cycle after the request, status writes ignored
    st_nxt.ack = cfg_req_i.valid;
    if (cfg_req_i.valid && !cfg_req_i.write) begin
      if (hit_cmd) begin
        st_nxt.rdata = cmd_stat_word;
      end else if (hit_class) begin
        st_nxt.rdata = class_word;
      end else begin
        st_nxt.rdata = 32'h0000_0000;
      end
    end
    if (cfg_req_i.valid && cfg_req_i.write && hit_cmd) begin
      st_nxt.cmd = cmd_wr;
    end

    // SERR# on address parity only when enabled, one cycle low
    st_nxt.serr_oe  = addr_parity_err_i && st_r.cmd[`PCC_CMD_SERR_EN];
    st_nxt.serr_lvl = !(addr_parity_err_i && st_r.cmd[`PCC_CMD_SERR_EN]);

    // PERR# as target only under parity response
    st_nxt.perr_oe  = data_parity_err_i && st_r.cmd[`PCC_CMD_PERR_RESP];
    st_nxt.perr_lvl = !(data_parity_err_i && st_r.cmd[`PCC_CMD_PERR_RESP]);

    // PERR# monitored as initiator; select chooses report only or also halt
    st_nxt.master_perr = perr_err && st_r.cmd[`PCC_CMD_PERR_RESP];
    st_nxt.master_halt = perr_err && st_r.cmd[`PCC_CMD_PERR_RESP] && parity_error_select_i;

    // master grant gated by bus master enable; a halt withholds the grant in each cycle it is raised
    st_nxt.master_grant = master_req_i && st_r.cmd[`PCC_CMD_MASTER] && !st_nxt.master_halt;

    // target claims gated by space enables; special cycles never claim
    st_nxt.mem_claim = mem_hit_i && st_r.cmd[`PCC_CMD_MEM] && !special_cycle_i;
    st_nxt.io_claim  = io_hit_i && st_r.cmd[`PCC_CMD_IO] && !special_cycle_i;
  end

  // single register for all state, synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state flip-flops
  assign cfg_ack_o           = st_r.ack;
  assign cfg_rdata_o         = st_r.rdata;
  assign serr_n_o            = st_r.serr_lvl;
  assign serr_oe_o           = st_r.serr_oe;
  assign perr_n_o            = st_r.perr_lvl;
  assign perr_oe_o           = st_r.perr_oe;
  assign io_claim_o          = st_r.io_claim;
  assign mem_claim_o         = st_r.mem_claim;
  assign master_grant_o      = st_r.master_grant;
  assign master_perr_o       = st_r.master_perr;
  assign master_halt_o       = st_r.master_halt;
  assign fast_back_to_back_o = st_r.cmd[`PCC_CMD_FAST_B2B];

  // serr_n_i is only the wire level; this block has no reason to watch it
  logic unused_serr;
  assign unused_serr = serr_n_i;

  // checks on configuration answers, error pins and gating
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // helper: request of the previous cycle
  logic       prev_rd_cmd;
  logic       prev_rd_class;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_rd_cmd   <= 1'b0;
      prev_rd_class <= 1'b0;
    end else begin
      prev_rd_cmd   <= cfg_req_i.valid && !cfg_req_i.write && hit_cmd;
      prev_rd_class <= cfg_req_i.valid && !cfg_req_i.write && hit_class;
    end
  end

  // reference command word built from the write stream alone, to judge read-back
  logic [15:0] shadow_cmd;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      shadow_cmd <= `PCC_CMD_RESET;
    end else if (cfg_req_i.valid && cfg_req_i.write && hit_cmd) begin
      shadow_cmd <= {cfg_req_i.be[1] ? cfg_req_i.wdata[15:8] & CMD_RW_MASK[15:8] : shadow_cmd[15:8],
                     cfg_req_i.be[0] ? cfg_req_i.wdata[7:0] & CMD_RW_MASK[7:0] : shadow_cmd[7:0]};
    end
  end

  a_no_66mhz:
    assert property (prev_rd_cmd |-> cfg_ack_o && !cfg_rdata_o[`PCC_STS_66MHZ])
    else $error("66 MHz capable bit read as one");

  a_cap_list_set:
    assert property (prev_rd_cmd |-> cfg_rdata_o[`PCC_STS_CAP_LIST])
    else $error("capability list bit read as zero");

  a_fast_b2b_write:
    assert property (cfg_req_i.valid && cfg_req_i.write && hit_cmd && cfg_req_i.be[1]
                     |=> fast_back_to_back_o == $past(cfg_req_i.wdata[`PCC_CMD_FAST_B2B]))
    else $error("fast back-to-back enable did not take the written value");

  a_serr_gate:
    assert property (addr_parity_err_i |=> (serr_oe_o && !serr_n_o) == $past(st_r.cmd[`PCC_CMD_SERR_EN]))
    else $error("SERR# drive does not follow its enable");

  a_serr_cause:
    assert property (serr_oe_o |-> $past(addr_parity_err_i))
    else $error("SERR# driven without an address parity error");

  a_ro_cmd_zero:
    assert property (prev_rd_cmd |-> cfg_rdata_o[`PCC_CMD_STEPPING:`PCC_CMD_SPECIAL] == 5'h00
                     || cfg_rdata_o[`PCC_CMD_PERR_RESP] && cfg_rdata_o[`PCC_CMD_STEPPING] == 1'b0
                        && cfg_rdata_o[`PCC_CMD_VGA_SNOOP:`PCC_CMD_SPECIAL] == 3'h0)
    else $error("a hardwired zero command bit read as one");

  a_perr_target:
    assert property (data_parity_err_i && st_r.cmd[`PCC_CMD_PERR_RESP]
                     |=> perr_oe_o && !perr_n_o ##1 (!perr_oe_o || $past(data_parity_err_i)))
    else $error("PERR# not driven for one cycle per target data parity error");

  a_parity_ignored:
    assert property (!st_r.cmd[`PCC_CMD_PERR_RESP] |=> !perr_oe_o && !master_perr_o && !master_halt_o)
    else $error("parity error acted on while response disabled");

  a_halt_select:
    assert property (master_halt_o |-> master_perr_o && $past(parity_error_select_i))
    else $error("halt raised without parity error select");

  a_cmd_const_bits:
    assert property (!st_r.cmd[`PCC_CMD_VGA_SNOOP] && !st_r.cmd[`PCC_CMD_MWI] && !st_r.cmd[`PCC_CMD_STEPPING])
    else $error("hardwired command bit stored as one");

  a_no_special:
    assert property (special_cycle_i |=> !io_claim_o && !mem_claim_o)
    else $error("special cycle was claimed");

  a_master_gate:
    assert property (master_grant_o |-> $past(master_req_i) && $past(st_r.cmd[`PCC_CMD_MASTER]))
    else $error("master grant while bus master disabled");

  a_mem_gate:
    assert property (mem_hit_i && !special_cycle_i |=> mem_claim_o == $past(st_r.cmd[`PCC_CMD_MEM]))
    else $error("memory claim does not follow memory enable");

  a_io_gate:
    assert property (io_hit_i && !special_cycle_i |=> io_claim_o == $past(st_r.cmd[`PCC_CMD_IO]))
    else $error("io claim does not follow io enable");

  a_class_value:
    assert property (prev_rd_class |-> cfg_rdata_o == {`PCC_BASE_CLASS, `PCC_SUB_CLASS, `PCC_PROG_IF, REVISION})
    else $error("class and revision word wrong");

  a_rsvd_zero:
    assert property (prev_rd_cmd |-> cfg_rdata_o[`PCC_STS_RSVD_HI:`PCC_STS_RSVD_LO] == 10'h000
                     && cfg_rdata_o[15:10] == 6'h00 && cfg_rdata_o[31:27] == 5'h00)
    else $error("reserved status bits read non-zero");

  a_cmd_readback:
    assert property (prev_rd_cmd |-> cfg_rdata_o[15:0] == shadow_cmd)
    else $error("command word read back differs from the writes");

  a_cmd_hold:
    assert property (!(cfg_req_i.valid && cfg_req_i.write && hit_cmd) |=> $stable(st_r.cmd))
    else $error("command word changed without a command write");

  a_sub_class:
    assert property (prev_rd_class |-> cfg_rdata_o[23:16] == `PCC_SUB_CLASS)
    else $error("sub class field wrong");

  a_prog_iface:
    assert property (prev_rd_class |-> cfg_rdata_o[15:8] == `PCC_PROG_IF)
    else $error("programming interface field wrong");

  a_revision_code:
    assert property (prev_rd_class |-> cfg_rdata_o[7:0] == REVISION)
    else $error("revision byte wrong");

  a_mwi_zero:
    assert property (prev_rd_cmd |-> !cfg_rdata_o[`PCC_CMD_MWI])
    else $error("memory write and invalidate enable read as one");

  a_special_zero:
    assert property (prev_rd_cmd |-> !cfg_rdata_o[`PCC_CMD_SPECIAL])
    else $error("special cycle enable read as one");

  a_snoop_zero:
    assert property (prev_rd_cmd |-> !cfg_rdata_o[`PCC_CMD_VGA_SNOOP])
    else $error("palette snoop bit read as one");

  a_serr_level:
    assert property (serr_oe_o == !serr_n_o)
    else $error("SERR# value and enable disagree");

  a_perr_level:
    assert property (perr_oe_o == !perr_n_o)
    else $error("PERR# value and enable disagree");

  a_perr_cause:
    assert property (perr_oe_o |-> $past(data_parity_err_i) && $past(st_r.cmd[`PCC_CMD_PERR_RESP]))
    else $error("PERR# driven without an enabled target data parity error");

  a_initiator_perr:
    assert property (master_perr_o |-> $past(master_active_i) && $past(st_r.cmd[`PCC_CMD_PERR_RESP]))
    else $error("initiator parity report without an active enabled master phase");

  a_halt_no_grant:
    assert property (master_halt_o |-> !master_grant_o)
    else $error("grant given in a halt cycle");

  a_claim_cause:
    assert property ((io_claim_o |-> $past(io_hit_i)) and (mem_claim_o |-> $past(mem_hit_i)))
    else $error("claim without a decode hit");

endmodule

`default_nettype wire

// ### design/pcc_pin_sync.sv
// three-stage pin synchroniser whose output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pcc_pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      level_o
);

  pcc_pkg::pcc_sync_s st_r;
  pcc_pkg::pcc_sync_s st_nxt;

  // ff1 feeds ff2 only; the agreement check looks at ff2 and ff3
  always_comb begin
    st_nxt       = st_r;
    st_nxt.ff1   = pin_i;
    st_nxt.ff2   = st_r.ff1;
    st_nxt.ff3   = st_r.ff2;
    if (st_r.ff2 == st_r.ff3) begin
      st_nxt.level = st_r.ff3;
    end
  end

  // synchronous reset to the idle level of the pin
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.level;

endmodule

`default_nettype wire

// ### design/pcc_pkg.sv
// types shared by the configuration command and class register block
package pcc_pkg;

  // one configuration cycle as handed over by the target decoder
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pcc_cfg_req_s;

  // state of the pin synchroniser
  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic level;
  } pcc_sync_s;

  // state of the register block
  typedef struct packed {
    logic [15:0] cmd;
    logic        ack;
    logic [31:0] rdata;
    logic        serr_oe;
    logic        serr_lvl;
    logic        perr_oe;
    logic        perr_lvl;
    logic        io_claim;
    logic        mem_claim;
    logic        master_grant;
    logic        master_perr;
    logic        master_halt;
  } pcc_state_s;

endpackage

// ### design/pcc_regs.svh
// offsets, field positions and fixed values of the configuration command and class registers
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH

// register byte offsets inside configuration space
`define PCC_OFF_CMD_STAT    8'h04
`define PCC_OFF_CLASS_REV   8'h08

// command word field positions
`define PCC_CMD_IO          0
`define PCC_CMD_MEM         1
`define PCC_CMD_MASTER      2
`define PCC_CMD_SPECIAL     3
`define PCC_CMD_MWI         4
`define PCC_CMD_VGA_SNOOP   5
`define PCC_CMD_PERR_RESP   6
`define PCC_CMD_STEPPING    7
`define PCC_CMD_SERR_EN     8
`define PCC_CMD_FAST_B2B    9

// status half field positions, counted in the 32-bit register
`define PCC_STS_RSVD_LO     10
`define PCC_STS_RSVD_HI     19
`define PCC_STS_CAP_LIST    20
`define PCC_STS_66MHZ       21
`define PCC_STS_UDF         22
`define PCC_STS_FAST_B2B_CAP 23

// command reset value and the mask of bits software may change
`define PCC_CMD_RESET       16'h0000
`define PCC_CMD_RW_MASK     16'h0347

// fixed status half: medium devsel, fast back-to-back capable, capability list
`define PCC_STS_VALUE       16'h0290

// class code fields
`define PCC_BASE_CLASS      8'h02
`define PCC_SUB_CLASS       8'h00
`define PCC_PROG_IF         8'h00

`endif

// ### tb/pcc_host_model.sv
// host bridge model that issues configuration cycles towards the register block
`timescale 1ns/1ps
`default_nettype none

module pcc_host_model (
  input  wire logic                  clk_i,
  output var pcc_pkg::pcc_cfg_req_s  cfg_req_o,
  input  wire logic                  cfg_ack_i,
  input  wire logic [31:0]           cfg_rdata_i
);
  initial cfg_req_o = '0;

  // one access: request stands one cycle, the answer is taken in the cycle after it
  task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                        input logic [31:0] wdata, output logic [31:0] rdata, output logic ack);
    @(negedge clk_i);
    cfg_req_o = '{valid: 1'b1, write: wr, addr: addr, be: be, wdata: wdata};
    @(negedge clk_i);
    ack = cfg_ack_i;
    rdata = cfg_rdata_i;
    // an idle port shows inverted values so stale fields never pass for a live request
    cfg_req_o = '{valid: 1'b0, write: ~wr, addr: ~addr, be: ~be, wdata: ~wdata};
  endtask
endmodule

`default_nettype wire

// ### tb/pci_config_command_class_tb.sv
// self-checking testbench for the configuration command, status and class registers
`timescale 1ns/1ps
`default_nettype none

module pci_config_command_class_tb;
  localparam logic [7:0] REV = 8'h5a; // arbitrary revision code

  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  pcc_pkg::pcc_cfg_req_s cfg_req;
  logic                  ack, serr_n, serr_oe, perr_n, perr_oe, fast_b2b;
  logic [31:0]           rdata;
  logic                  io_hit = 0, mem_hit = 0, special = 0, m_req = 0, m_act = 0;
  logic                  a_err = 0, d_err = 0, sel = 0, perr_drv = 1;
  logic                  io_claim, mem_claim, grant, m_perr, m_halt;
  wire                   serr_wire = serr_oe ? serr_n : 1'b1;
  // wired-and of both parties on the pulled-up error line
  wire                   perr_wire = (perr_oe ? perr_n : 1'b1) & perr_drv;
  int                    compares = 0;
  int                    miscompares = 0;

  always #25 clk = ~clk;

  pcc_host_model u_host (.clk_i(clk), .cfg_req_o(cfg_req), .cfg_ack_i(ack), .cfg_rdata_i(rdata));

  pcc_cfg_cmd #(.REVISION(REV)) u_dut (
    .clk_i(clk), .rst_n_i(rst_n), .cfg_req_i(cfg_req), .cfg_ack_o(ack), .cfg_rdata_o(rdata),
    .io_hit_i(io_hit), .mem_hit_i(mem_hit), .special_cycle_i(special), .master_req_i(m_req),
    .master_active_i(m_act), .addr_parity_err_i(a_err), .data_parity_err_i(d_err),
    .parity_error_select_i(sel), .serr_n_i(serr_wire), .serr_n_o(serr_n), .serr_oe_o(serr_oe),
    .perr_n_i(perr_wire), .perr_n_o(perr_n), .perr_oe_o(perr_oe), .io_claim_o(io_claim),
    .mem_claim_o(mem_claim), .master_grant_o(grant), .master_perr_o(m_perr),
    .master_halt_o(m_halt), .fast_back_to_back_o(fast_b2b));

  task automatic finish_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] r;
    logic        k;
    u_host.access(1'b1, a, be, d, r, k);
    check({31'h0, k}, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        k;
    u_host.access(1'b0, a, 4'hf, 32'h0, r, k);
    check({31'h0, k}, 32'h1);
    check(r, exp);
  endtask

  // fixed fields and the cleared command word straight after reset
  task automatic t_reset_values();
    rd(8'h04, 32'h0290_0000);
    rd(8'h08, {24'h02_00_00, REV});
    rd(8'h40, 32'h0);
    check({31'h0, fast_b2b}, 32'h0);
    $display("test reset_values done");
  endtask

  // byte lanes, read-only command bits and ignored writes
  task automatic t_command_bits();
    wr(8'h04, 4'h1, 32'hffff_ffff);
    rd(8'h04, 32'h0290_0047);
    check({31'h0, fast_b2b}, 32'h0);
    wr(8'h04, 4'hf, 32'hffff_ffff);
    rd(8'h04, 32'h0290_0347);
    check({31'h0, fast_b2b}, 32'h1);
    wr(8'h08, 4'hf, 32'hffff_ffff);
    rd(8'h08, {24'h02_00_00, REV});
    wr(8'h04, 4'hf, 32'h0);
    rd(8'h04, 32'h0290_0000);
    $display("test command_bits done");
  endtask

  // every combination of the three enables against hits, then a special cycle
  task automatic t_decode();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(8'h04, 4'hf, {29'h0, c});
      @(negedge clk);
      {io_hit, mem_hit, m_req, special} = 4'b1110;
      @(negedge clk);
      check({31'h0, io_claim}, {31'h0, c[0]});
      check({31'h0, mem_claim}, {31'h0, c[1]});
      check({31'h0, grant}, {31'h0, c[2]});
      special = 1'b1;
      @(negedge clk);
      check({30'h0, io_claim, mem_claim}, 32'h0);
      {io_hit, mem_hit, m_req, special} = 4'b0000;
    end
    $display("test decode done");
  endtask

  // parity pulses with the error enables off and on; the drive lasts one cycle
  task automatic t_error_pins();
    logic en;
    for (int i = 0; i < 2; i++) begin
      en = i[0];
      wr(8'h04, 4'hf, {23'h0, en, 1'b0, en, 6'h0});
      @(negedge clk);
      {a_err, d_err} = 2'b11;
      @(negedge clk);
      {a_err, d_err} = 2'b00;
      check({30'h0, serr_oe, serr_n}, {30'h0, en, ~en});
      check({30'h0, perr_oe, perr_n}, {30'h0, en, ~en});
      @(negedge clk);
      check({30'h0, serr_oe, perr_oe}, 32'h0);
    end
    $display("test error_pins done");
  endtask

  // initiator watches the error line: off, report only, report and halt
  task automatic t_initiator_perr();
    logic [1:0] cfg;
    int         n_perr;
    int         n_halt;
    for (int i = 0; i < 3; i++) begin
      cfg = i[1:0];
      n_perr = 0;
      n_halt = 0;
      wr(8'h04, 4'hf, {25'h0, cfg != 2'd0, 6'h4});
      @(negedge clk);
      {m_act, m_req, sel} = {2'b11, cfg == 2'd2};
      for (int k = 0; k < 12; k++) begin
        perr_drv = (k >= 3);
        @(negedge clk);
        if (m_perr === 1'b1) n_perr++;
        if (m_halt === 1'b1) begin
          n_halt++;
          check({31'h0, grant}, 32'h0);
        end
      end
      check({31'h0, n_perr != 0}, {31'h0, cfg != 2'd0});
      check({31'h0, n_halt != 0}, {31'h0, cfg == 2'd2});
      {m_act, m_req, sel} = 3'b000;
    end
    $display("test initiator_perr done");
  endtask

  // a reset in mid-run clears the command word again; the first read follows one cycle after release
  task automatic t_mid_reset();
    wr(8'h04, 4'hf, 32'h0000_0347);
    check({31'h0, fast_b2b}, 32'h1);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    check({31'h0, fast_b2b}, 32'h0);
    check({31'h0, ack}, 32'h0);
    rst_n = 1'b1;
    rd(8'h04, 32'h0290_0000);
    $display("test mid_reset done");
  endtask

  // bounded at 5000 cycles, some 38 times the roughly 130 cycles the tests need
  initial begin
    #(50 * 5000);
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_reset_values();
    t_command_bits();
    t_decode();
    t_error_pins();
    t_initiator_perr();
    t_mid_reset();
    finish_test();
  end
endmodule

`default_nettype wire
